//--- src/wspc_pkg.sv
// constants for the wait/stop power control block
package wspc_pkg;
  localparam int unsigned CLK_MHZ = 125;
  // oscillator restart settle time in microseconds, counted on the restarted clock
  localparam int unsigned SETTLE_US = 4;
  localparam int unsigned SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int unsigned CNT_W = 16;
  // interrupt option register layout
  localparam logic [7:0] IOR_RESET = 8'h00;
  localparam int unsigned IOR_GEN_BIT = 4;
  // interrupt sources: bit 0 is the non-maskable source
  localparam int unsigned NSRC = 5;
  localparam int unsigned NMI_BIT = 0;
  typedef enum logic [1:0] {
    WSPC_CTX_MAIN,
    WSPC_CTX_IRQ,
    WSPC_CTX_NMI
  } wspc_ctx_t;
  typedef enum logic [2:0] {
    WSPC_RUN,
    WSPC_IDLE,
    WSPC_DEEP,
    WSPC_SETTLE,
    WSPC_RESUME
  } wspc_state_t;
  typedef enum logic [1:0] {
    WSPC_RES_NEXT,
    WSPC_RES_IRQ,
    WSPC_RES_NMI
  } wspc_resume_t;
endpackage

//--- src/wspc_wake_sync.sv
// wake request capture and two-stage synchroniser
`timescale 1ns/1ps
module wspc_wake_sync (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic wake_raw,
  output logic wake_sync
);
  logic meta_ff;
  logic sync_ff;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else if (ce) begin
      meta_ff <= wake_raw;
      sync_ff <= meta_ff;
    end
  end
  assign wake_sync = sync_ff;
endmodule // wspc_wake_sync

//--- src/wspc_top.sv
// wait/stop power-saving sequencer for a small core
// How it works
// - idle instruction freezes the core; state kept, peripherals run
// - oscillator keeps running during idle
// - enabled peripheral interrupt wakes the core from idle
// - reset from pin or watchdog ends idle through normal reset
// - interrupt wake from idle resumes with no settle delay
// - deep stop only allowed while watchdog is disabled
// - deep stop halts core and oscillator until interrupt or reset
// - reset pin ends deep stop through normal reset
// - interrupt wake from deep stop waits the settle delay first
// - waking by interrupt keeps the oscillator selection
// - slept in main: run interrupt routine, then next instruction
// - slept in nmi routine: continue next instruction, stay nmi context
// - slept in irq routine, normal irq wakes: continue routine
// - slept in irq routine, nmi wakes: run nmi routine, then continue
// - active watchdog turns deep stop into idle
// - global enable cleared: only reset restarts, nmi gives no wake
// - no power-saving entry while an enabled request is pending
// - global enable is bit 4 of write-only option register, reset zero
// - requests sampled at each instruction end, branching to service
`timescale 1ns/1ps
module wspc_top #(
  parameter int unsigned SETTLE_CYC = wspc_pkg::SETTLE_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic idle_instr,
  input wire logic deep_instr,
  input wire logic instr_end,
  input wire logic [1:0] core_ctx,
  input wire logic ior_wr,
  input wire logic [7:0] ior_wdata,
  input wire logic [wspc_pkg::NSRC-1:0] irq_req,
  input wire logic [wspc_pkg::NSRC-1:0] irq_pin,
  input wire logic wdog_active,
  output logic core_halt,
  output logic osc_stop,
  output logic resume_valid,
  output logic [1:0] resume_kind,
  output logic take_irq,
  output logic global_interrupt_enable
);
  localparam logic [wspc_pkg::CNT_W-1:0] SETTLE_N = SETTLE_CYC[wspc_pkg::CNT_W-1:0];
  wspc_pkg::wspc_state_t state_ff, nxt_state;
  logic [7:0] interrupt_option_reg_ff;
  logic [wspc_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  wspc_pkg::wspc_ctx_t ctx_ff;
  logic halt_ff, osc_stop_ff, rv_ff, take_ff;
  logic [1:0] rk_ff, nxt_rk;
  logic [wspc_pkg::NSRC-1:0] pin_sync;
  logic [wspc_pkg::CNT_W-1:0] span_ff;

  wire gen = interrupt_option_reg_ff[wspc_pkg::IOR_GEN_BIT];
  wire nmi_req = irq_req[wspc_pkg::NMI_BIT];
  wire mask_req = |irq_req[wspc_pkg::NSRC-1:1];
  // wake only with global enable set; nmi too
  wire wake_any = gen && (nmi_req || mask_req);
  wire pending = nmi_req || (gen && mask_req);
  wire save_go = (idle_instr || deep_instr) && !pending;
  wire go_deep = deep_instr && !wdog_active;
  // pin path is asynchronous: synchronised per bit on the restarted clock, then gated
  wire pin_wake = gen && (|pin_sync);
  wire pin_nmi = gen && pin_sync[wspc_pkg::NMI_BIT];
  wire wake_nmi = nmi_req || pin_nmi;
  wire settle_done = (cnt_ff == SETTLE_N - 16'h0001);

  function automatic logic [1:0] resume_of(input wspc_pkg::wspc_ctx_t c, input logic nmi);
    logic [1:0] r;
    r = wspc_pkg::WSPC_RES_NEXT;
    case (c)
      wspc_pkg::WSPC_CTX_MAIN: r = nmi ? wspc_pkg::WSPC_RES_NMI : wspc_pkg::WSPC_RES_IRQ;
      wspc_pkg::WSPC_CTX_NMI: r = wspc_pkg::WSPC_RES_NEXT;
      wspc_pkg::WSPC_CTX_IRQ: r = nmi ? wspc_pkg::WSPC_RES_NMI : wspc_pkg::WSPC_RES_NEXT;
      default: r = wspc_pkg::WSPC_RES_NEXT;
    endcase
    return r;
  endfunction

  // each pin bit gets its own two flops before any logic looks at it
  for (genvar i = 0; i < wspc_pkg::NSRC; i++) begin : g_pin_sync
    wspc_wake_sync u_sync (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .ce(ce),
      .wake_raw(irq_pin[i]),
      .wake_sync(pin_sync[i])
    );
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_rk = rk_ff;
    case (state_ff)
      wspc_pkg::WSPC_RUN: begin
        if (save_go) begin
          nxt_state = go_deep ? wspc_pkg::WSPC_DEEP : wspc_pkg::WSPC_IDLE;
        end
      end
      wspc_pkg::WSPC_IDLE: begin
        if (wake_any) begin
          nxt_state = wspc_pkg::WSPC_RESUME;
          nxt_rk = resume_of(ctx_ff, nmi_req);
        end
      end
      wspc_pkg::WSPC_DEEP: begin
        if (pin_wake || wake_any) begin
          nxt_state = wspc_pkg::WSPC_SETTLE;
          nxt_cnt = '0;
          nxt_rk = resume_of(ctx_ff, wake_nmi);
        end
      end
      wspc_pkg::WSPC_SETTLE: begin
        nxt_cnt = cnt_ff + 16'h0001;
        if (settle_done) begin
          nxt_state = wspc_pkg::WSPC_RESUME;
        end
      end
      wspc_pkg::WSPC_RESUME: nxt_state = wspc_pkg::WSPC_RUN;
      default: nxt_state = wspc_pkg::WSPC_RUN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_ff <= wspc_pkg::WSPC_RUN;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cnt_ff <= '0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rk_ff <= wspc_pkg::WSPC_RES_NEXT;
    end else if (ce) begin
      rk_ff <= nxt_rk;
    end
  end

  // option register: write only, cleared on reset
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      interrupt_option_reg_ff <= wspc_pkg::IOR_RESET;
    end else if (ce && ior_wr) begin
      interrupt_option_reg_ff <= ior_wdata;
    end
  end

  // context is captured when the core enters a power-saving state
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctx_ff <= wspc_pkg::WSPC_CTX_MAIN;
    end else if (ce && state_ff == wspc_pkg::WSPC_RUN && save_go) begin
      ctx_ff <= wspc_pkg::wspc_ctx_t'(core_ctx);
    end
  end

  // next values of the registered outputs
  wire nxt_halt = (nxt_state != wspc_pkg::WSPC_RUN) &&
    (nxt_state != wspc_pkg::WSPC_RESUME);
  // oscillator runs in idle, stops only in deep; selection untouched
  wire nxt_osc_stop = (nxt_state == wspc_pkg::WSPC_DEEP);
  wire nxt_rv = (nxt_state == wspc_pkg::WSPC_RESUME);
  // interrupt taken at instruction end only while running
  wire nxt_take = (state_ff == wspc_pkg::WSPC_RUN) && instr_end && pending &&
    !save_go;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      halt_ff <= 1'b0;
    end else if (ce) begin
      halt_ff <= nxt_halt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      osc_stop_ff <= 1'b0;
    end else if (ce) begin
      osc_stop_ff <= nxt_osc_stop;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rv_ff <= 1'b0;
    end else if (ce) begin
      rv_ff <= nxt_rv;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      take_ff <= 1'b0;
    end else if (ce) begin
      take_ff <= nxt_take;
    end
  end

  // cycles spent settling since the core last ran; read by the checks only
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      span_ff <= '0;
    end else if (ce) begin
      if (state_ff == wspc_pkg::WSPC_SETTLE) begin
        span_ff <= span_ff + 16'h0001;
      end else if (state_ff == wspc_pkg::WSPC_RUN) begin
        span_ff <= '0;
      end
    end
  end

  assign core_halt = halt_ff;
  assign osc_stop = osc_stop_ff;
  assign resume_valid = rv_ff;
  assign resume_kind = rk_ff;
  assign take_irq = take_ff;
  assign global_interrupt_enable = interrupt_option_reg_ff[wspc_pkg::IOR_GEN_BIT];

  // entry into the power-saving states
  sequence s_enter_idle;
    ce && state_ff == wspc_pkg::WSPC_RUN && save_go && !go_deep;
  endsequence
  sequence s_enter_deep;
    ce && state_ff == wspc_pkg::WSPC_RUN && save_go && go_deep;
  endsequence
  a_idle_entry: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_enter_idle |=> state_ff == wspc_pkg::WSPC_IDLE && core_halt && !osc_stop)
    else $error("idle entry wrong");
  a_deep_entry: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_enter_deep |=> state_ff == wspc_pkg::WSPC_DEEP && core_halt && osc_stop)
    else $error("deep entry wrong");
  a_deep_wdog_off: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && state_ff == wspc_pkg::WSPC_RUN && wdog_active |=> !osc_stop)
    else $error("deep stop entered with watchdog active");
  a_wdog_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && state_ff == wspc_pkg::WSPC_RUN && save_go && deep_instr && wdog_active
    |=> state_ff == wspc_pkg::WSPC_IDLE)
    else $error("deep stop not turned into idle");
  a_pending_blocks: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && state_ff == wspc_pkg::WSPC_RUN && pending |=> !core_halt)
    else $error("entered power saving with request pending");
  a_halt_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_ff == wspc_pkg::WSPC_IDLE |-> core_halt)
    else $error("core not halted in idle");
  a_idle_osc_runs: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_ff == wspc_pkg::WSPC_IDLE |-> !osc_stop)
    else $error("oscillator stopped during idle");

  // staying asleep
  a_deep_halted: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_ff == wspc_pkg::WSPC_DEEP |-> core_halt && osc_stop)
    else $error("deep stop not halted");
  a_deep_stays: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && state_ff == wspc_pkg::WSPC_DEEP && !wake_any && !pin_wake |=> state_ff == wspc_pkg::WSPC_DEEP)
    else $error("deep stop left without wake");
  a_idle_stays: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && state_ff == wspc_pkg::WSPC_IDLE && !wake_any |=> state_ff == wspc_pkg::WSPC_IDLE && core_halt)
    else $error("idle left without wake");
  a_gen_low_sleep: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && state_ff == wspc_pkg::WSPC_IDLE && !gen |=> state_ff == wspc_pkg::WSPC_IDLE)
    else $error("woke with global enable clear");
  a_gen_low_deep: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && state_ff == wspc_pkg::WSPC_DEEP && !gen |=> state_ff == wspc_pkg::WSPC_DEEP)
    else $error("deep woke with global enable clear");

  // waking up
  sequence s_idle_wake;
    ce && state_ff == wspc_pkg::WSPC_IDLE && wake_any;
  endsequence
  a_idle_wake_fast: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_idle_wake |=> resume_valid)
    else $error("idle wake delayed");
  sequence s_deep_wake;
    ce && state_ff == wspc_pkg::WSPC_DEEP && wake_any;
  endsequence
  a_deep_wake_settle: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_deep_wake |=> state_ff == wspc_pkg::WSPC_SETTLE && !resume_valid)
    else $error("deep wake skipped settling");
  sequence s_pin_wake;
    ce && state_ff == wspc_pkg::WSPC_DEEP && pin_wake && !wake_any;
  endsequence
  a_pin_wake_settle: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_pin_wake |=> state_ff == wspc_pkg::WSPC_SETTLE && !resume_valid)
    else $error("pin wake skipped settling");
  a_settle_osc: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_ff == wspc_pkg::WSPC_SETTLE |-> core_halt && !osc_stop)
    else $error("settling with core running or oscillator stopped");
  a_settle_len: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_ff == wspc_pkg::WSPC_RESUME && span_ff != '0 |-> span_ff == SETTLE_N)
    else $error("settle delay length wrong");
  a_resume_run: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && state_ff == wspc_pkg::WSPC_RESUME |=> state_ff == wspc_pkg::WSPC_RUN && !core_halt)
    else $error("core not released after wake");

  // resume path chosen from the saved context
  a_main_irq_kind: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_idle_wake ##0 (ctx_ff == wspc_pkg::WSPC_CTX_MAIN && !nmi_req)
    |=> resume_kind == wspc_pkg::WSPC_RES_IRQ)
    else $error("main context wake kind wrong");
  a_main_nmi_kind: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_idle_wake ##0 (ctx_ff == wspc_pkg::WSPC_CTX_MAIN && nmi_req)
    |=> resume_kind == wspc_pkg::WSPC_RES_NMI)
    else $error("main context nmi wake kind wrong");
  a_irq_ctx_kind: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_idle_wake ##0 (ctx_ff == wspc_pkg::WSPC_CTX_IRQ && !nmi_req)
    |=> resume_kind == wspc_pkg::WSPC_RES_NEXT)
    else $error("irq context wake kind wrong");
  a_irq_nmi_kind: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_idle_wake ##0 (ctx_ff == wspc_pkg::WSPC_CTX_IRQ && nmi_req)
    |=> resume_kind == wspc_pkg::WSPC_RES_NMI)
    else $error("irq context nmi wake kind wrong");
  a_nmi_ctx_next: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_ff == wspc_pkg::WSPC_RESUME && ctx_ff == wspc_pkg::WSPC_CTX_NMI
    |-> rk_ff == wspc_pkg::WSPC_RES_NEXT)
    else $error("nmi context resume wrong");

  // interrupt branch, option register and reset
  a_take_at_end: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && state_ff == wspc_pkg::WSPC_RUN && instr_end && pending && !save_go
    |=> take_irq)
    else $error("request not taken at instruction end");
  a_take_running: assert property (@(posedge sys_clk) disable iff (!resetn)
    take_irq |-> !core_halt)
    else $error("branch signalled while halted");
  a_ior_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && ior_wr
    |=> global_interrupt_enable == $past(ior_wdata[wspc_pkg::IOR_GEN_BIT]))
    else $error("global enable not written");
  a_ior_reset: assert property (@(posedge sys_clk)
    !resetn |=> !global_interrupt_enable)
    else $error("global enable not cleared by reset");
  a_reset_quiet: assert property (@(posedge sys_clk)
    !resetn |=> !core_halt && !osc_stop && !resume_valid && !take_irq)
    else $error("outputs not cleared by reset");
endmodule // wspc_top

//--- bench/wspc_core_model.sv
// core stand-in: ends an instruction every fourth cycle while running
`timescale 1ns/1ps
module wspc_core_model (
  input wire logic sys_clk,
  input wire logic core_halt,
  output logic instr_end
);
  logic [1:0] cnt_ff = 2'h0;
  always_ff @(negedge sys_clk) begin
    cnt_ff <= cnt_ff + 2'h1;
    instr_end <= (cnt_ff == 2'h3) && !core_halt;
  end
endmodule // wspc_core_model

//--- bench/wait_stop_power_control_bench.sv
// self-checking bench for the wait/stop sequencer
`timescale 1ns/1ps
module wait_stop_power_control_bench;
  localparam int unsigned SC = 4;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic idle_instr = 1'b0;
  logic deep_instr = 1'b0;
  logic ior_wr = 1'b0;
  logic wdog_active = 1'b0;
  logic [1:0] core_ctx = 2'h0;
  logic [7:0] ior_wdata = 8'h00;
  logic [4:0] irq_req = 5'h00;
  logic [4:0] irq_pin = 5'h00;
  logic instr_end, core_halt, osc_stop, resume_valid, take_irq, gen;
  logic [1:0] resume_kind;
  int err_total = 0;
  int compares = 0;
  int n, k;
  always #4 sys_clk = ~sys_clk;
  wspc_top #(.SETTLE_CYC(SC)) i_dut (.sys_clk(sys_clk), .resetn(resetn), .ce(1'b1),
    .idle_instr(idle_instr), .deep_instr(deep_instr), .instr_end(instr_end),
    .core_ctx(core_ctx), .ior_wr(ior_wr), .ior_wdata(ior_wdata), .irq_req(irq_req),
    .irq_pin(irq_pin), .wdog_active(wdog_active), .core_halt(core_halt),
    .osc_stop(osc_stop), .resume_valid(resume_valid), .resume_kind(resume_kind),
    .take_irq(take_irq), .global_interrupt_enable(gen));
  wspc_core_model i_core (.sys_clk(sys_clk), .core_halt(core_halt), .instr_end(instr_end));
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cyc(int c);
    repeat (c) @(negedge sys_clk);
  endtask
  task automatic set_gen(logic g);
    ior_wdata = ($urandom() & 8'hef) | {3'h0, g, 4'h0};
    ior_wr = 1'b1;
    cyc(1);
    ior_wr = 1'b0;
    cyc(1);
    chk("gen", gen, g);
  endtask
  function automatic logic [1:0] exp_kind(logic [1:0] ctx, logic nmi);
    if (ctx == 2'h2) return 2'h0;
    if (nmi) return 2'h2;
    return (ctx == 2'h0) ? 2'h1 : 2'h0;
  endfunction
  // enter a power-saving state, wake it, check timing and resume path
  task automatic nap(logic deep, logic [1:0] ctx, int src, logic pin);
    core_ctx = ctx;
    idle_instr = !deep;
    deep_instr = deep;
    cyc(1);
    idle_instr = 1'b0;
    deep_instr = 1'b0;
    cyc(1);
    chk("halt", core_halt, 1'b1);
    chk("osc_stop", osc_stop, deep && !wdog_active);
    if (pin) irq_pin[src] = 1'b1;
    else irq_req[src] = 1'b1;
    n = 0;
    while (resume_valid !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    if (deep && !wdog_active) chk("settle", n > SC, 1'b1);
    else chk("no_delay", n < SC, 1'b1);
    chk("kind", resume_kind, exp_kind(ctx, src == 0));
    chk("osc_kept", osc_stop, 1'b0);
    irq_req = 5'h00;
    irq_pin = 5'h00;
    cyc(2);
  endtask
  initial begin
    void'($urandom(75));
    cyc(4);
    resetn = 1'b1;
    chk("gen_rst", gen, 1'b0);
    set_gen(1'b1);
    for (k = 0; k < 6; k++) nap(k[0], 2'(k / 2), k[0] ? 0 : 3, k[0]);
    for (int i = 0; i < 8; i++) begin
      k = $urandom();
      wdog_active = k[7];
      nap(k[0], k[2:1] % 3, k[5:3] % 5, k[0] && !k[7] && k[6]);
    end
    wdog_active = 1'b0;
    irq_req = 5'h08;
    idle_instr = 1'b1;
    cyc(1);
    idle_instr = 1'b0;
    n = 0;
    while (take_irq !== 1'b1 && n < 8) begin
      cyc(1);
      n++;
    end
    chk("take_irq", n < 8, 1'b1);
    chk("pend_block", core_halt, 1'b0);
    irq_req = 5'h00;
    set_gen(1'b0);
    idle_instr = 1'b1;
    cyc(1);
    idle_instr = 1'b0;
    irq_req = 5'h01;
    cyc(10);
    chk("gen_off_wake", core_halt, 1'b1);
    irq_req = 5'h00;
    resetn = 1'b0;
    cyc(1);
    resetn = 1'b1;
    chk("rst_exit", core_halt, 1'b0);
    tally_and_finish();
  end
  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end
endmodule // wait_stop_power_control_bench
